//--- hw/acl_comparator_ctrl.sv
// How it works
// RQ1: Mux enable bit 3, read/write, resets zero
// RQ2: Mux on, converter off: channel picks negative
// RQ3: Otherwise dedicated negative pin drives comparator
// RQ4: Bit 7 powers comparator off, resets zero
// RQ5: Software disables interrupt before power change
// RQ6: Bit 6 selects bandgap for positive input
// RQ7: Bit 5 shows synchronised output, 1-2 cycles
// RQ8: Matching output event sets flag bit 4
// RQ9: Interrupt needs flag, enable, global enable
// RQ10: Flag cleared by vector or written one
// RQ11: Bit 2 routes output to capture logic
// RQ12: Software enables capture interrupt in timer
// RQ13: Mode 00 toggle, 10 fall, 11 rise
// RQ14: Software disables interrupt before mode change
// RQ15: Consecutive samples compared; reserved never sets
// RQ16: Writable bits reset zero; output bit follows
//
// Implementation choices: the register addresses and strobed register access.
module acl_comparator_ctrl
    import acl_pkg::*;
(
    // Clock and reset
    input  wire logic       SYS_CLK_I,
    input  wire logic       RESETN_I,
    // Register port
    input  wire logic [1:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // Comparator core
    input  wire logic       CMP_RESULT_I,
    output logic            CMP_POWER_OFF_O,
    output logic            BANDGAP_POSITIVE_SELECT_O,
    output logic      [3:0] NEG_INPUT_SEL_O,
    // Converter state
    input  wire logic       CONVERTER_ENABLE_I,
    input  wire logic [2:0] CHANNEL_SELECT_FIELD_I,
    // Processor interrupt
    input  wire logic       GLOBAL_IRQ_ENABLE_I,
    input  wire logic       IRQ_VECTOR_TAKEN_I,
    output logic            CMP_IRQ_REQ_O,
    // Capture front end
    output logic            CAPTURE_INPUT_O,
    // Summary interrupt
    output logic            IRQ_O
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;        // Writable control bits, 5:4 held zero
    logic       irq_flag_reg;    // Comparator event flag
    logic       mux_enable_reg;  // Negative mux enable
    logic       sync1_reg;       // Synchroniser stage one
    logic       sync2_reg;       // Synchronised output
    logic       prev_reg;        // Previous synchronised sample
    logic [7:0] evt_status_reg;  // Sticky event status
    logic [7:0] evt_mask_reg;    // Event mask
    logic       event_hit;       // Event matches mode
    logic       wr_ctrl;         // Write to control register
    logic       rd_status;       // Read of event status

    assign wr_ctrl   = WR_I && (ADDR_I == ADDR_CTRL_STATUS);
    assign rd_status = RD_I && (ADDR_I == ADDR_IRQ_STATUS);

    // ------------------------------------------------------------
    // Synchroniser and event detect
    // ------------------------------------------------------------
    // Two flops; stage one feeds only stage two
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end
        else
        begin
            sync1_reg <= CMP_RESULT_I;  // RQ7
            sync2_reg <= sync1_reg;     // RQ7
            prev_reg  <= sync2_reg;     // RQ15
        end
    end

    // Mode decode on consecutive samples
    always_comb
    begin
        unique case (ctrl_reg[1:0])
            MODE_TOGGLE: event_hit = sync2_reg ^ prev_reg;         // RQ13
            MODE_RSVD:   event_hit = 1'b0;                         // RQ15
            MODE_FALL:   event_hit = prev_reg && !sync2_reg;       // RQ13
            MODE_RISE:   event_hit = !prev_reg && sync2_reg;       // RQ13
        endcase
    end

    // ------------------------------------------------------------
    // Control register and flag
    // ------------------------------------------------------------
    // Plain writable bits; flag and output bit kept out of this register
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            ctrl_reg <= CTRL_RESET;  // RQ16
        else if (wr_ctrl)
            ctrl_reg <= {WDATA_I[7:6], 2'b00, WDATA_I[3:0]};  // RQ4
    end

    // Flag: set beats clear by vector or write one
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            irq_flag_reg <= 1'b0;  // RQ16
        else if (event_hit)
            irq_flag_reg <= 1'b1;  // RQ8
        else if (IRQ_VECTOR_TAKEN_I || (wr_ctrl && WDATA_I[BIT_IRQ_FLAG]))
            irq_flag_reg <= 1'b0;  // RQ10
    end

    // Special function bit
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            mux_enable_reg <= 1'b0;  // RQ1
        else if (WR_I && (ADDR_I == ADDR_SPECIAL_FN))
            mux_enable_reg <= WDATA_I[BIT_MUX_ENABLE];  // RQ1
    end

    // ------------------------------------------------------------
    // Sticky status and mask
    // ------------------------------------------------------------
    // Bit 0 comparator event, bit 1 flag raised to processor
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            evt_status_reg <= 8'h00;
            evt_mask_reg   <= MASK_RESET;
        end
        else
        begin
            if (WR_I && (ADDR_I == ADDR_IRQ_MASK))
                evt_mask_reg <= WDATA_I;
            if (rd_status)
                evt_status_reg <= {6'h00, CMP_IRQ_REQ_O, event_hit};  // Set wins
            else
                evt_status_reg <= evt_status_reg | {6'h00, CMP_IRQ_REQ_O, event_hit};
        end
    end

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            RDATA_O                   <= 8'h00;
            CMP_POWER_OFF_O           <= 1'b0;
            BANDGAP_POSITIVE_SELECT_O <= 1'b0;
            NEG_INPUT_SEL_O           <= NEG_PIN_SEL;
            CMP_IRQ_REQ_O             <= 1'b0;
            CAPTURE_INPUT_O           <= 1'b0;
            IRQ_O                     <= 1'b0;
        end
        else
        begin
            CMP_POWER_OFF_O           <= ctrl_reg[BIT_POWER_OFF];    // RQ4
            BANDGAP_POSITIVE_SELECT_O <= ctrl_reg[BIT_BANDGAP_SEL];  // RQ6
            if (mux_enable_reg && !CONVERTER_ENABLE_I)
                NEG_INPUT_SEL_O <= {1'b0, CHANNEL_SELECT_FIELD_I};   // RQ2
            else
                NEG_INPUT_SEL_O <= NEG_PIN_SEL;                      // RQ3
            CMP_IRQ_REQ_O   <= irq_flag_reg && ctrl_reg[BIT_IRQ_ENABLE]
                               && GLOBAL_IRQ_ENABLE_I;               // RQ9
            CAPTURE_INPUT_O <= ctrl_reg[BIT_CAPTURE_EN] && sync2_reg;  // RQ11
            IRQ_O           <= |(evt_status_reg & evt_mask_reg);
            // Read mux, reads zero when no read strobe
            RDATA_O <= 8'h00;
            if (RD_I)
            begin
                unique case (ADDR_I)
                    ADDR_CTRL_STATUS: RDATA_O <= {ctrl_reg[7:6], sync2_reg, irq_flag_reg,
                                                  ctrl_reg[3:0]};
                    ADDR_SPECIAL_FN:  RDATA_O <= {4'h0, mux_enable_reg, 3'h0};
                    ADDR_IRQ_STATUS:  RDATA_O <= evt_status_reg;
                    ADDR_IRQ_MASK:    RDATA_O <= evt_mask_reg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Flag, enable and global enable all up
    sequence s_flag_up;
        irq_flag_reg && ctrl_reg[BIT_IRQ_ENABLE] && GLOBAL_IRQ_ENABLE_I;
    endsequence

    // Software writes one to the flag with no event in that cycle
    sequence s_flag_write_one;
        wr_ctrl && WDATA_I[BIT_IRQ_FLAG] && !event_hit;
    endsequence

    // Synchronised output went low to high
    sequence s_sync_rise;
        !prev_reg && sync2_reg;
    endsequence

    // Synchronised output went high to low
    sequence s_sync_fall;
        prev_reg && !sync2_reg;
    endsequence

    // Two stages between pin and output bit
    a_sync_delay: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ7
        sync2_reg == $past(CMP_RESULT_I, 2)) else $error("sync output delay wrong");

    // Any matching event leaves the flag set
    a_event_sets_flag: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ8
        event_hit |=> irq_flag_reg) else $error("event missed flag");

    // Request follows flag, enable and global enable
    a_irq_request: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ9
        s_flag_up |=> CMP_IRQ_REQ_O) else $error("irq request missing");

    // No request while the enable is low
    a_irq_no_enable: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ9
        !ctrl_reg[BIT_IRQ_ENABLE] |=> !CMP_IRQ_REQ_O) else $error("irq without enable");

    // No request while the processor masks everything
    a_irq_no_global: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ9
        !GLOBAL_IRQ_ENABLE_I |=> !CMP_IRQ_REQ_O) else $error("irq without global");

    // No request without a pending flag
    a_irq_no_flag: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ9
        !irq_flag_reg |=> !CMP_IRQ_REQ_O) else $error("irq without flag");

    // Vector clears the flag unless a new event lands
    a_vector_clears: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ10
        IRQ_VECTOR_TAKEN_I && !event_hit |=> !irq_flag_reg)
        else $error("vector did not clear flag");

    // Writing one clears the flag
    a_write_clears: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ10
        s_flag_write_one |=> !irq_flag_reg) else $error("write one did not clear flag");

    // Reserved mode never raises an event
    a_rsvd_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ15
        ctrl_reg[1:0] == MODE_RSVD |-> !event_hit) else $error("reserved mode set flag");

    // Rise mode sees every rising sample pair
    a_rise_mode: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ13
        ctrl_reg[1:0] == MODE_RISE && $rose(sync2_reg) |-> event_hit)
        else $error("rise not detected");

    // Rise mode ignores falling samples
    a_rise_only: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ13
        (ctrl_reg[1:0] == MODE_RISE) ##0 s_sync_fall |-> !event_hit)
        else $error("fall seen in rise mode");

    // Fall mode sees every falling sample pair
    a_fall_mode: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ13
        (ctrl_reg[1:0] == MODE_FALL) ##0 s_sync_fall |-> event_hit)
        else $error("fall not detected");

    // Fall mode ignores rising samples
    a_fall_only: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ13
        (ctrl_reg[1:0] == MODE_FALL) ##0 s_sync_rise |-> !event_hit)
        else $error("rise seen in fall mode");

    // Toggle mode sees both directions
    a_toggle_mode: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ13
        (ctrl_reg[1:0] == MODE_TOGGLE) && (sync2_reg != prev_reg) |-> event_hit)
        else $error("toggle not detected");

    // A steady output never makes an event
    a_steady_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ15
        (sync2_reg == prev_reg) |-> !event_hit) else $error("event without change");

    // Channel field drives the negative input when borrowed
    a_neg_mux: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ2
        mux_enable_reg && !CONVERTER_ENABLE_I
        |=> NEG_INPUT_SEL_O == {1'b0, $past(CHANNEL_SELECT_FIELD_I)})
        else $error("channel not selected");

    // Converter running keeps the dedicated pin
    a_neg_pin: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ3
        CONVERTER_ENABLE_I |=> NEG_INPUT_SEL_O == NEG_PIN_SEL) else $error("pin not selected");

    // Mux disabled keeps the dedicated pin
    a_mux_off_pin: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ3
        !mux_enable_reg |=> NEG_INPUT_SEL_O == NEG_PIN_SEL) else $error("pin lost with mux off");

    // Special register write lands in the mux enable
    a_mux_bit_write: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ1
        WR_I && (ADDR_I == ADDR_SPECIAL_FN) |=> mux_enable_reg == $past(WDATA_I[BIT_MUX_ENABLE]))
        else $error("mux enable not written");

    // Power off output follows its control bit
    a_power_follow: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ4
        CMP_POWER_OFF_O == $past(ctrl_reg[BIT_POWER_OFF])) else $error("power off not driven");

    // Bandgap select output follows its control bit
    a_bandgap_follow: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ6
        BANDGAP_POSITIVE_SELECT_O == $past(ctrl_reg[BIT_BANDGAP_SEL]))
        else $error("bandgap select not driven");

    // Capture path stays quiet when not routed
    a_capture_off: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ11
        !ctrl_reg[BIT_CAPTURE_EN] |=> !CAPTURE_INPUT_O) else $error("capture leaked");

    // Capture path carries the synchronised output when routed
    a_capture_follow: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ11
        ctrl_reg[BIT_CAPTURE_EN] |=> CAPTURE_INPUT_O == $past(sync2_reg))
        else $error("capture not following output");

    // Control read shows the synchronised output bit
    a_ctrl_read_sync: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RQ7
        RD_I && (ADDR_I == ADDR_CTRL_STATUS) |=> RDATA_O[BIT_SYNC_OUT] == $past(sync2_reg))
        else $error("output bit not read back");
endmodule

//--- hw/acl_pkg.sv
package acl_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;  // Comparator control/status
    localparam logic [1:0] ADDR_SPECIAL_FN  = 2'h1;  // Negative mux enable lives here
    localparam logic [1:0] ADDR_IRQ_STATUS  = 2'h2;  // Sticky event status
    localparam logic [1:0] ADDR_IRQ_MASK    = 2'h3;  // Event mask

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_POWER_OFF   = 7;  // Comparator power off
    localparam int BIT_BANDGAP_SEL = 6;  // Bandgap onto positive input
    localparam int BIT_SYNC_OUT    = 5;  // Synchronised output, read only
    localparam int BIT_IRQ_FLAG    = 4;  // Event flag
    localparam int BIT_IRQ_ENABLE  = 3;  // Interrupt enable
    localparam int BIT_CAPTURE_EN  = 2;  // Route output to capture logic
    localparam int BIT_MUX_ENABLE  = 3;  // Negative mux enable in special reg

    // ------------------------------------------------------------
    // Reset values and event modes
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_RSVD   = 2'h1;
    localparam logic [1:0] MODE_FALL   = 2'h2;
    localparam logic [1:0] MODE_RISE   = 2'h3;
    localparam logic [3:0] NEG_PIN_SEL = 4'h8;  // Negative input from dedicated pin
endpackage

//--- tb/acl_cmp_model.sv
// ----------------------------------------
// Behavioural comparator core
// ----------------------------------------
module acl_cmp_model (
    // Control from the block
    input  wire logic       power_off_i,
    input  wire logic       bandgap_sel_i,
    input  wire logic [3:0] neg_sel_i,
    // Analog difference seen by the bench
    input  wire logic       level_i,
    // Comparator result
    output logic            result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Unpowered core reads low; channel pins sit above the positive side
    assign result_o = !power_off_i && neg_sel_i[3] && (bandgap_sel_i || level_i);
endmodule

//--- tb/acl_comparator_ctrl_tb.sv
// ----------------------------------------
// Self-checking bench for the comparator control
// ----------------------------------------
module acl_comparator_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acl_pkg::*;
    logic       clk = 0, rst_n = 0, wr = 0, rd = 0, cmp, lvl = 0;   // Clock, strobes
    logic       adc_en = 0, glob = 0, vec = 0, pwr, bg, cap, req, irq; // Side signals
    logic [1:0] addr = 0;                                             // Register index
    logic [2:0] chan = 0;                                             // Channel field
    logic [3:0] nsel;                                                 // Negative select
    logic [7:0] wdat = 0, rdat, d;                                    // Data paths
    int         n_fail = 0, check_count = 0;                          // Counters
    always #4 clk = ~clk;
    acl_comparator_ctrl i_acl_comparator_ctrl (.SYS_CLK_I(clk), .RESETN_I(rst_n),
        .ADDR_I(addr), .WDATA_I(wdat), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat),
        .CMP_RESULT_I(cmp), .CMP_POWER_OFF_O(pwr), .BANDGAP_POSITIVE_SELECT_O(bg),
        .NEG_INPUT_SEL_O(nsel), .CONVERTER_ENABLE_I(adc_en), .CHANNEL_SELECT_FIELD_I(chan),
        .GLOBAL_IRQ_ENABLE_I(glob), .IRQ_VECTOR_TAKEN_I(vec), .CMP_IRQ_REQ_O(req),
        .CAPTURE_INPUT_O(cap), .IRQ_O(irq));
    acl_cmp_model i_acl_cmp_model (.power_off_i(pwr), .bandgap_sel_i(bg),
        .neg_sel_i(nsel), .level_i(lvl), .result_o(cmp));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a; wdat <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdat;
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_reset_and_mux;
        rreg(ADDR_CTRL_STATUS, d); chk(d, 8'h00);
        chk({4'h0, nsel}, {4'h0, NEG_PIN_SEL});
        wreg(ADDR_SPECIAL_FN, 8'hFF); rreg(ADDR_SPECIAL_FN, d); chk(d, 8'h08);
        for (int c = 0; c < 8; c++)
        begin
            chan <= c[2:0]; cyc(2); chk({4'h0, nsel}, c[7:0]);
        end
        adc_en <= 1'b1; cyc(2); chk({4'h0, nsel}, {4'h0, NEG_PIN_SEL});
        adc_en <= 1'b0; wreg(ADDR_SPECIAL_FN, 8'h00); cyc(2);
        chk({4'h0, nsel}, {4'h0, NEG_PIN_SEL});
    endtask
    task automatic sc_power_bandgap_capture;
        wreg(ADDR_CTRL_STATUS, 8'hE4); cyc(2); chk({6'h0, pwr, bg}, 8'h03);
        rreg(ADDR_CTRL_STATUS, d); chk(d, 8'hC4);
        wreg(ADDR_CTRL_STATUS, 8'h04); lvl <= 1'b1; cyc(4);
        rreg(ADDR_CTRL_STATUS, d); chk(d, 8'h34);
        chk({7'h0, cap}, 8'h01);
        wreg(ADDR_CTRL_STATUS, 8'h00); cyc(2); chk({7'h0, cap}, 8'h00);
        lvl <= 1'b0; cyc(5);
    endtask
    task automatic sc_modes;
        logic [1:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = i[1:0];
            // Enable stays low while the mode changes
            wreg(ADDR_CTRL_STATUS, {6'h04, m}); cyc(5);
            rreg(ADDR_CTRL_STATUS, d); chk({7'h0, d[4]}, 8'h00);
            lvl <= 1'b1; cyc(5); rreg(ADDR_CTRL_STATUS, d);
            chk({7'h0, d[4]}, {7'h0, m == MODE_TOGGLE || m == MODE_RISE});
            wreg(ADDR_CTRL_STATUS, {6'h04, m}); lvl <= 1'b0; cyc(5); rreg(ADDR_CTRL_STATUS, d);
            chk({7'h0, d[4]}, {7'h0, m == MODE_TOGGLE || m == MODE_FALL});
        end
    endtask
    task automatic sc_interrupts;
        chk({7'h0, irq}, 8'h00);
        wreg(ADDR_CTRL_STATUS, 8'h10); lvl <= 1'b1; cyc(5);
        wreg(ADDR_CTRL_STATUS, 8'h08); glob <= 1'b1; cyc(3); chk({7'h0, req}, 8'h01);
        glob <= 1'b0; cyc(3); chk({7'h0, req}, 8'h00);
        @(posedge clk) vec <= 1'b1;
        @(posedge clk) vec <= 1'b0;
        cyc(2); rreg(ADDR_CTRL_STATUS, d); chk({7'h0, d[4]}, 8'h00);
        wreg(ADDR_IRQ_MASK, 8'h01); lvl <= 1'b0; cyc(5); chk({7'h0, irq}, 8'h01);
        rreg(ADDR_IRQ_STATUS, d); chk({7'h0, d[0]}, 8'h01);
        cyc(3); chk({7'h0, irq}, 8'h00);
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        cyc(2);
        rst_n <= 1'b1;
        sc_reset_and_mux();
        sc_power_bandgap_capture();
        sc_modes();
        sc_interrupts();
        complete_run();
    end
    initial
    begin
        #200000;
        n_fail++;
        complete_run();
    end
endmodule
